// file: rtl/rtc_status_flags.sv
// Status flags, control bits, interrupt pin and clock output of the clock block.
// Assumes comparator and halt-sense levels arrive asynchronously, alarm
// matches and month starts are one-cycle pulses on clk, power-up drives arst_n.
// How it works
// - Threshold select picks 1.3 V or 2.1 V
// - Low supply sets sticky flag, stops monitoring
// - Writing zero clears low-supply flag, restarts
// - Oscillator halt clears good flag; writes stored
// - Power-up sets power-on flag, held
// - Power-on flag zeroes control and adjust bits
// - Writing zero clears power-on flag only
// - Crystal clock out unless both disables set
// - Periodic flag mirrors periodic low output
// - Level mode: writing zero releases periodic pin
// - Enabled alarm flags set 61 us after match
// - Writing zero clears alarm flag, releases pin
// - Disabled alarm flag reads zero
// - Seconds and minutes count BCD 00-59
// - Hours carry into day counters at midnight
// - Seconds write resets sub-second divider
// - Time registers zero their unused upper bits
// - Weekday counts 0 to 6, wraps
// - Hour mode bit: 0 twelve-hour, 1 twenty-four
// - Alarm enable bits gate alarm circuits
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module rtc_status_flags #(
	parameter int unsigned XTAL_PER_SEC    = rtc_pkg::XTAL_PER_SEC,
	parameter int unsigned ALARM_DELAY_CYC = rtc_pkg::ALARM_DELAY_CYC
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	input  wire logic       xtal_clk,
	input  wire logic       supply_below_2v1,
	input  wire logic       supply_below_1v3,
	input  wire logic       osc_halt,
	input  wire logic [1:0] alarm_match,
	input  wire logic       month_start,
	output logic            irq_n,
	output logic            crystal_clock_out
);
	localparam int unsigned DW = $clog2(XTAL_PER_SEC);      // Divider width
	localparam int unsigned CW = $clog2(ALARM_DELAY_CYC + 1); // Alarm delay width
	localparam int unsigned NA = 2;                          // Alarm channels: 0 daily, 1 weekly

	// ---- Input synchronisers ----
	logic [3:0] sync_a_q;    // First stage, read only by second stage
	logic [3:0] sync_b_q;    // Second stage, safe to use
	logic       xtal_prev_q; // Previous crystal level for edge finding
	wire  [3:0] async_in = {osc_halt, supply_below_1v3, supply_below_2v1, xtal_clk};
	wire        xtal_s   = sync_b_q[0];
	wire        below_hi = sync_b_q[1];
	wire        below_lo = sync_b_q[2];
	wire        halt_s   = sync_b_q[3];
	wire        xtal_rise = xtal_s & ~xtal_prev_q;

	// Two flip-flops for every outside level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_a_q    <= 4'h0;
			sync_b_q    <= 4'h0;
			xtal_prev_q <= 1'b0;
		end else begin
			sync_a_q    <= async_in;
			sync_b_q    <= sync_a_q;
			xtal_prev_q <= xtal_s;
		end
	end

	// ---- Register port decode ----
	wire wr_sec   = reg_we && reg_addr == rtc_pkg::OFF_SECONDS;
	wire wr_adj   = reg_we && reg_addr == rtc_pkg::OFF_OSC_ADJ;
	wire wr_ctrl  = reg_we && reg_addr == rtc_pkg::OFF_CONTROL;
	wire wr_stat  = reg_we && reg_addr == rtc_pkg::OFF_STATUS;
	// Write-zero clears; a one written to these bits does nothing
	wire clr_low  = wr_stat && !reg_wdata[rtc_pkg::BIT_LOW_SUPPLY];
	wire clr_pon  = wr_stat && !reg_wdata[rtc_pkg::BIT_POWER_ON];
	wire clr_per  = wr_stat && !reg_wdata[rtc_pkg::BIT_PERIODIC];
	wire [NA-1:0] clr_alarm = {wr_stat && !reg_wdata[rtc_pkg::BIT_WEEKLY_FLAG],
		wr_stat && !reg_wdata[rtc_pkg::BIT_DAILY_FLAG]};

	// ---- Sub-second divider ----
	logic [DW-1:0] div_q; // Crystal edges within the current second
	wire div_last = div_q == DW'(XTAL_PER_SEC - 1);
	// A seconds write restarts the second, so no tick in that cycle
	wire sec_tick = xtal_rise & div_last & ~wr_sec;

	// Divider counts crystal rising edges
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= '0;
		end else if (wr_sec) begin
			div_q <= '0;
		end else if (xtal_rise) begin
			div_q <= div_last ? '0 : div_q + DW'(1);
		end
	end

	// ---- Time counters ----
	time_if tk ();
	logic [7:0] ctrl_q; // Control register: enables, hour mode, clock disable, periodic select
	assign tk.sec_tick = sec_tick;
	assign tk.wr_en    = reg_we;
	assign tk.wr_addr  = reg_addr;
	assign tk.wr_data  = reg_wdata;
	assign tk.mode_24  = ctrl_q[rtc_pkg::BIT_MODE_24];

	rtc_timekeeper u_timekeeper (
		.clk    (clk),
		.arst_n (arst_n),
		.tk     (tk.keeper)
	);

	// ---- Control and adjustment registers ----
	logic       pon_q;     // Power-on flag
	logic [6:0] osc_adj_q; // Adjustment value, stored for the rate trimmer
	logic       thr_sel_q; // Supply threshold select
	logic       clkdis_a_q; // Clock output disable, status register copy

	// Power-on flag holds every control bit at zero until cleared
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q     <= 8'h00;
			osc_adj_q  <= 7'h00;
			thr_sel_q  <= 1'b0;
			clkdis_a_q <= 1'b0;
		end else if (pon_q) begin
			ctrl_q     <= 8'h00;
			osc_adj_q  <= 7'h00;
			thr_sel_q  <= 1'b0;
			clkdis_a_q <= 1'b0;
		end else begin
			ctrl_q     <= wr_ctrl ? reg_wdata : ctrl_q;
			osc_adj_q  <= wr_adj ? reg_wdata[6:0] : osc_adj_q;
			thr_sel_q  <= wr_stat ? reg_wdata[rtc_pkg::BIT_THR_SEL] : thr_sel_q;
			clkdis_a_q <= wr_stat ? reg_wdata[rtc_pkg::BIT_CLKDIS_A] : clkdis_a_q;
		end
	end

	// ---- Supply monitor, oscillator and power-on flags ----
	logic low_q;  // Low-supply result, sticky
	logic xst_q;  // Oscillation-good flag
	// High select means the lower threshold
	wire sel_below = thr_sel_q ? below_lo : below_hi;
	// Monitoring runs only while the flag is clear
	wire low_set   = !low_q && sel_below;

	// Low-supply flag: a zero write or the power-on flag clears it and restarts monitoring
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_q <= 1'b0;
		end else if (pon_q) begin
			low_q <= 1'b0;
		end else if (low_set) begin
			low_q <= 1'b1;
		end else if (clr_low) begin
			low_q <= 1'b0;
		end
	end

	// Halt sensing beats a host write of one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xst_q <= rtc_pkg::OSC_GOOD_RST;
		end else if (halt_s) begin
			xst_q <= 1'b0;
		end else if (wr_stat) begin
			xst_q <= reg_wdata[rtc_pkg::BIT_OSC_GOOD];
		end
	end

	// Power-up from zero is the reset; the flag then waits for a zero write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pon_q <= rtc_pkg::POWER_ON_RST;
		end else if (clr_pon) begin
			pon_q <= 1'b0;
		end
	end

	// ---- Periodic interrupt ----
	logic level_q; // Level-mode latch, low pin while set
	rtc_pkg::per_sel_t per_sel;
	assign per_sel = rtc_pkg::per_sel_t'(ctrl_q[rtc_pkg::BIT_PER_SEL_LSB +: 3]);
	wire level_mode = per_sel[2];
	// Pulse modes are low for the first half of each cycle after the second step
	wire low_1hz    = ~div_q[DW-1];
	wire low_2hz    = ~div_q[DW-2];
	wire level_evt  = (per_sel == rtc_pkg::PER_SECOND && sec_tick) ||
		(per_sel == rtc_pkg::PER_MINUTE && tk.min_carry) ||
		(per_sel == rtc_pkg::PER_HOUR && tk.hour_carry) ||
		(per_sel == rtc_pkg::PER_MONTH && month_start);
	wire per_low    = (per_sel == rtc_pkg::PER_LOW) ||
		(per_sel == rtc_pkg::PER_2HZ && low_2hz) ||
		(per_sel == rtc_pkg::PER_1HZ && low_1hz) ||
		(level_mode && level_q);

	// New interrupt cycle wins over a zero write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_q <= 1'b0;
		end else if (!level_mode) begin
			level_q <= 1'b0;
		end else if (level_evt) begin
			level_q <= 1'b1;
		end else if (clr_per) begin
			level_q <= 1'b0;
		end
	end

	// ---- Alarm flags, one channel per alarm ----
	logic [NA-1:0] alarm_en;   // Alarm enables from the control register
	logic [NA-1:0] alarm_flag; // Flags as seen by pin and reads
	logic [CW-1:0] alarm_cnt_q [NA]; // Cycles left before the flag sets
	logic          alarm_flg_q [NA]; // Stored flags
	assign alarm_en = {ctrl_q[rtc_pkg::BIT_WEEKLY_EN], ctrl_q[rtc_pkg::BIT_DAILY_EN]};

	for (genvar g = 0; g < NA; g++) begin : g_alarm
		wire fire = alarm_cnt_q[g] == CW'(1);
		// Delay from match to flag; a disabled alarm drops any pending match
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				alarm_cnt_q[g] <= '0;
			end else if (!alarm_en[g]) begin
				alarm_cnt_q[g] <= '0;
			end else if (alarm_match[g]) begin
				alarm_cnt_q[g] <= CW'(ALARM_DELAY_CYC);
			end else if (alarm_cnt_q[g] != '0) begin
				alarm_cnt_q[g] <= alarm_cnt_q[g] - CW'(1);
			end
		end
		// Setting wins over a zero write landing in the same cycle
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				alarm_flg_q[g] <= 1'b0;
			end else if (!alarm_en[g]) begin
				alarm_flg_q[g] <= 1'b0;
			end else if (fire) begin
				alarm_flg_q[g] <= 1'b1;
			end else if (clr_alarm[g]) begin
				alarm_flg_q[g] <= 1'b0;
			end
		end
		assign alarm_flag[g] = alarm_flg_q[g] & alarm_en[g];
	end

	// ---- Pins ----
	wire any_src  = per_low | (|alarm_flag);
	wire clk_hold = clkdis_a_q & ctrl_q[rtc_pkg::BIT_CLKDIS_B];

	// Both pins come from flops; one cycle later than the sources
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_n             <= 1'b1;
			crystal_clock_out <= 1'b1;
		end else begin
			irq_n             <= ~any_src;
			crystal_clock_out <= clk_hold ? 1'b1 : xtal_s;
		end
	end

	// ---- Read path ----
	wire [7:0] stat_rd = {thr_sel_q, low_q, xst_q, pon_q, clkdis_a_q, per_low, alarm_flag[1], alarm_flag[0]};
	wire [7:0] rd_mux  = (reg_addr == rtc_pkg::OFF_SECONDS) ? tk.sec :
		(reg_addr == rtc_pkg::OFF_MINUTES) ? tk.min :
		(reg_addr == rtc_pkg::OFF_HOURS)   ? tk.hr :
		(reg_addr == rtc_pkg::OFF_WEEKDAY) ? tk.wday :
		(reg_addr == rtc_pkg::OFF_OSC_ADJ) ? {1'b0, osc_adj_q} :
		(reg_addr == rtc_pkg::OFF_CONTROL) ? ctrl_q :
		(reg_addr == rtc_pkg::OFF_STATUS)  ? stat_rd : 8'h00;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_re ? rd_mux : 8'h00;
		end
	end

	// ---- Checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	thr_select_a: assert property ($rose(low_q) |-> $past(thr_sel_q ? below_lo : below_hi))
		else $error("low-supply flag set without selected comparator");
	low_hold_a: assert property (low_q && !clr_low && !pon_q |=> low_q)
		else $error("low-supply flag dropped without a zero write");
	low_clear_a: assert property (low_q && clr_low && !pon_q |=> !low_q)
		else $error("zero write did not clear low-supply flag");
	osc_halt_a: assert property (halt_s |=> !xst_q ##1 (!xst_q || $past(wr_stat)))
		else $error("oscillation-good flag not held low after halt");
	pon_hold_a: assert property (pon_q && !clr_pon |=> pon_q)
		else $error("power-on flag dropped by itself");
	pon_clears_a: assert property (pon_q |=> ctrl_q == 8'h00 && !low_q && !level_q && irq_n)
		else $error("power-on did not clear control state");
	pon_zero_a: assert property (pon_q && clr_pon |=> !pon_q)
		else $error("zero write did not clear power-on flag");
	clk_out_a: assert property (clk_hold |=> crystal_clock_out)
		else $error("clock output not held high when disabled");
	per_read_a: assert property (reg_re && reg_addr == rtc_pkg::OFF_STATUS |=>
		reg_rdata[rtc_pkg::BIT_PERIODIC] == !irq_n || $past(|alarm_flag))
		else $error("periodic flag read disagrees with pin");
	level_clr_a: assert property (level_mode && level_q && clr_per && !level_evt && !pon_q
		|=> !level_q)
		else $error("level-mode zero write did not release pin");
	alarm_fire_a: assert property ($rose(alarm_flg_q[0]) |-> $past(alarm_cnt_q[0]) == CW'(1))
		else $error("daily alarm flag set without delay expiry");
	alarm_clr_a: assert property (alarm_flg_q[1] && clr_alarm[1] && alarm_cnt_q[1] != CW'(1)
		|=> !alarm_flg_q[1])
		else $error("zero write did not clear weekly alarm flag");
	alarm_read_a: assert property (reg_re && reg_addr == rtc_pkg::OFF_STATUS && !alarm_en[1]
		|=> reg_rdata[rtc_pkg::BIT_WEEKLY_FLAG] == 1'b0)
		else $error("disabled alarm flag read as one");
	div_reset_a: assert property (wr_sec |=> div_q == '0)
		else $error("seconds write did not reset divider");
	irq_or_a: assert property (irq_n == !$past(any_src))
		else $error("interrupt pin not OR of sources");
	alarm_set_c: cover property (alarm_match[0] && alarm_en[0]);
	level_clr_c: cover property (level_q && clr_per);
	pon_clear_c: cover property (pon_q && clr_pon);
	low_set_c: cover property ($rose(low_q));
endmodule // rtc_status_flags
`default_nettype wire

// file: rtl/rtc_pkg.sv
// Shared constants of the real-time clock status and time-counter block.
// Assumes a 200 MHz system clock and a 32.768 kHz crystal sampled by it.
`default_nettype none
package rtc_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] OFF_SECONDS  = 4'h0;
	localparam logic [3:0] OFF_MINUTES  = 4'h1;
	localparam logic [3:0] OFF_HOURS    = 4'h2;
	localparam logic [3:0] OFF_WEEKDAY  = 4'h3;
	localparam logic [3:0] OFF_OSC_ADJ  = 4'h7;
	localparam logic [3:0] OFF_CONTROL  = 4'he;
	localparam logic [3:0] OFF_STATUS   = 4'hf;
	// Control register fields
	localparam int unsigned BIT_WEEKLY_EN   = 7;
	localparam int unsigned BIT_DAILY_EN    = 6;
	localparam int unsigned BIT_MODE_24     = 5;
	localparam int unsigned BIT_CLKDIS_B    = 4;
	localparam int unsigned BIT_PER_SEL_LSB = 0;
	// Status and flags register fields
	localparam int unsigned BIT_THR_SEL     = 7;
	localparam int unsigned BIT_LOW_SUPPLY  = 6;
	localparam int unsigned BIT_OSC_GOOD    = 5;
	localparam int unsigned BIT_POWER_ON    = 4;
	localparam int unsigned BIT_CLKDIS_A    = 3;
	localparam int unsigned BIT_PERIODIC    = 2;
	localparam int unsigned BIT_WEEKLY_FLAG = 1;
	localparam int unsigned BIT_DAILY_FLAG  = 0;
	// Reset values
	localparam logic       POWER_ON_RST = 1'b1;
	localparam logic       OSC_GOOD_RST = 1'b0;
	localparam logic [7:0] HOURS_RST    = 8'h12;
	// Timing
	localparam int unsigned XTAL_PER_SEC    = 32768;
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned ALARM_DELAY_US  = 61;
	localparam int unsigned ALARM_DELAY_CYC = ALARM_DELAY_US * CLK_MHZ;
	// Periodic interrupt selections
	typedef enum logic [2:0] {
		PER_OFF    = 3'b000,
		PER_LOW    = 3'b001,
		PER_2HZ    = 3'b010,
		PER_1HZ    = 3'b011,
		PER_SECOND = 3'b100,
		PER_MINUTE = 3'b101,
		PER_HOUR   = 3'b110,
		PER_MONTH  = 3'b111
	} per_sel_t;
endpackage
`default_nettype wire

// file: rtl/time_if.sv
// Carrier between the flag logic and the time counters.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface time_if;
	logic       sec_tick;   // One-cycle pulse per elapsed second
	logic       wr_en;      // Register write strobe
	logic [3:0] wr_addr;    // Register write offset
	logic [7:0] wr_data;    // Register write data
	logic       mode_24;    // High selects 24-hour counting
	logic [7:0] sec;        // Seconds, BCD
	logic [7:0] min;        // Minutes, BCD
	logic [7:0] hr;         // Hours, BCD with PM or twenties bit
	logic [7:0] wday;       // Weekday code
	logic       min_carry;  // Pulse when seconds wrap
	logic       hour_carry; // Pulse when minutes wrap
	logic       day_carry;  // Pulse when hours wrap
	modport keeper (input sec_tick, wr_en, wr_addr, wr_data, mode_24,
		output sec, min, hr, wday, min_carry, hour_carry, day_carry);
	modport ctrl (output sec_tick, wr_en, wr_addr, wr_data, mode_24,
		input sec, min, hr, wday, min_carry, hour_carry, day_carry);
endinterface
`default_nettype wire

// file: rtl/rtc_timekeeper.sv
// Seconds, minutes, hours and weekday counters in BCD.
// Assumes a one-cycle second tick and writes arriving through the carrier.
`timescale 1ns/10ps
`default_nettype none
module rtc_timekeeper (
	input  wire logic clk,
	input  wire logic arst_n,
	time_if.keeper    tk
);
	logic [6:0] sec_q;        // Seconds counter
	logic [6:0] min_q;        // Minutes counter
	logic [5:0] hr_q;         // Hours counter
	logic [2:0] wday_q;       // Weekday counter
	logic       min_carry_q;  // Minute event
	logic       hour_carry_q; // Hour event
	logic       day_carry_q;  // Day event

	// Two-digit BCD increment, no wrap
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	wire [7:0] sec_inc  = bcd_inc({1'b0, sec_q});
	wire [7:0] min_inc  = bcd_inc({1'b0, min_q});
	wire [7:0] h12_inc  = bcd_inc({3'b000, hr_q[4:0]});
	wire [7:0] h24_inc  = bcd_inc({2'b00, hr_q});
	wire       sec_wrap = sec_q == 7'h59;
	wire       min_wrap = min_q == 7'h59;
	// Day boundary: 23 to 00, or PM11 to AM12
	wire       hr_wrap  = tk.mode_24 ? (hr_q == 6'h23) : (hr_q == 6'h31);
	// 12-hour step: AM12 to 1, 11 to 12 with the half-day bit toggled
	wire [5:0] h12_next = (hr_q[4:0] == 5'h12) ? {hr_q[5], 5'h01} :
		(hr_q[4:0] == 5'h11) ? {~hr_q[5], 5'h12} : {hr_q[5], h12_inc[4:0]};
	wire [5:0] hr_next  = hr_wrap ? (tk.mode_24 ? 6'h00 : 6'h12) :
		(tk.mode_24 ? h24_inc[5:0] : h12_next);
	wire       step_min = tk.sec_tick & sec_wrap;
	wire       step_hr  = step_min & min_wrap;
	wire       step_day = step_hr & hr_wrap;
	wire       wr_sec   = tk.wr_en && tk.wr_addr == rtc_pkg::OFF_SECONDS;
	wire       wr_min   = tk.wr_en && tk.wr_addr == rtc_pkg::OFF_MINUTES;
	wire       wr_hr    = tk.wr_en && tk.wr_addr == rtc_pkg::OFF_HOURS;
	wire       wr_wday  = tk.wr_en && tk.wr_addr == rtc_pkg::OFF_WEEKDAY;

	// Counters: a host write wins over a carry in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sec_q  <= 7'h00;
			min_q  <= 7'h00;
			hr_q   <= rtc_pkg::HOURS_RST[5:0];
			wday_q <= 3'h0;
		end else begin
			sec_q  <= wr_sec ? tk.wr_data[6:0] : (tk.sec_tick ? (sec_wrap ? 7'h00 : sec_inc[6:0]) : sec_q);
			min_q  <= wr_min ? tk.wr_data[6:0] : (step_min ? (min_wrap ? 7'h00 : min_inc[6:0]) : min_q);
			hr_q   <= wr_hr ? tk.wr_data[5:0] : (step_hr ? hr_next : hr_q);
			wday_q <= wr_wday ? tk.wr_data[2:0] : (step_day ? ((wday_q == 3'h6) ? 3'h0 : wday_q + 3'h1) : wday_q);
		end
	end

	// Carry events toward the periodic selector and the calendar
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			min_carry_q  <= 1'b0;
			hour_carry_q <= 1'b0;
			day_carry_q  <= 1'b0;
		end else begin
			min_carry_q  <= step_min;
			hour_carry_q <= step_hr;
			day_carry_q  <= step_day;
		end
	end

	// Unused upper bits read as zero
	assign tk.sec        = {1'b0, sec_q};
	assign tk.min        = {1'b0, min_q};
	assign tk.hr         = {2'b00, hr_q};
	assign tk.wday       = {5'h00, wday_q};
	assign tk.min_carry  = min_carry_q;
	assign tk.hour_carry = hour_carry_q;
	assign tk.day_carry  = day_carry_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sec_wrap_a: assert property (tk.sec_tick && sec_wrap && !wr_sec |=> sec_q == 7'h00 && min_carry_q)
		else $error("seconds did not wrap with a carry");
	wday_wrap_a: assert property (step_day && wday_q == 3'h6 && !wr_wday |=> wday_q == 3'h0)
		else $error("weekday did not wrap after six");
endmodule // rtc_timekeeper
`default_nettype wire

// file: testbench/host_model.sv
// Host side of the register port: one-cycle strobes, read notes kept in exp_q.
// Assumes the block answers a read in the next cycle and never waits.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic       clk,
	output logic      [3:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_we,
	output logic            reg_re
);
	logic [7:0] exp_q [$]; // Expected read data, oldest first
	// Idle port at time zero
	initial begin
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		reg_we    = 1'b0;
		reg_re    = 1'b0;
	end
	// Callers keep times valid; weekday writes may set bits above the three the counter keeps
	// Released lines show the inverse, so a stale value never passes for a hold
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask
	// Read: the note is queued when the strobe goes out
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_re   <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule // host_model
`default_nettype wire

// file: testbench/rtc_status_flags_tb_top.sv
// Self-checking bench for the status flags and time counters.
// Assumes short counts: 16 crystal rises a second, 20-cycle alarm delay.
`timescale 1ns/10ps
`default_nettype none
module rtc_status_flags_tb_top;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       xtal_clk = 1'b0;
	logic       supply_below_2v1 = 1'b0;
	logic       supply_below_1v3 = 1'b0;
	logic       osc_halt = 1'b0;
	logic [1:0] alarm_match = 2'b00;
	logic       month_start = 1'b0; // Month-start event from the calendar side
	logic       rd_q = 1'b0;       // Read strobe seen last edge
	wire  [3:0] reg_addr;
	wire  [7:0] reg_wdata;
	wire        reg_we;
	wire        reg_re;
	logic [7:0] reg_rdata;
	logic       irq_n;
	logic       crystal_clock_out;
	logic [7:0] s;                 // Random seconds value
	int         fail_count = 0;
	int         n_checks = 0;
	int         cyc_n = 0;
	int         n;
	logic [7:0] hs [2] = '{8'h23, 8'h31}; // Hour before midnight, 24h then 12h
	logic [7:0] he [2] = '{8'h00, 8'h12}; // Hour after midnight
	logic [7:0] ws [2] = '{8'h06, 8'h02}; // Weekday before
	logic [7:0] we [2] = '{8'h00, 8'h03}; // Weekday after
	always #2.5 clk = ~clk;
	// Crystal at 64 ns, phase offset from clk
	initial begin
		#1.3;
		forever #32 xtal_clk = ~xtal_clk;
	end
	host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re));
	rtc_status_flags #(.XTAL_PER_SEC(16), .ALARM_DELAY_CYC(20)) rtc_status_flags_i (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .xtal_clk(xtal_clk), .supply_below_2v1(supply_below_2v1),
		.supply_below_1v3(supply_below_1v3), .osc_halt(osc_halt), .alarm_match(alarm_match),
		.month_start(month_start), .irq_n(irq_n), .crystal_clock_out(crystal_clock_out));
	task automatic wrap_up();
		if (fail_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: read data %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: pin level %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Counts low samples of the clock output once the sync lag is past
	task automatic lows(output int k);
		k = 0;
		cyc(4);
		repeat (100) begin
			@(posedge clk);
			if (crystal_clock_out !== 1'b1) k++;
		end
	endtask
	task automatic alarm_pulse(input logic [1:0] g);
		@(posedge clk);
		alarm_match <= g;
		@(posedge clk);
		alarm_match <= 2'b00;
	endtask
	// Monitor: read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= reg_re;
		if (rd_q) chk_rd(reg_rdata, host_model_i.exp_q.pop_front());
	end
	// Hang guard
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 10000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		cyc(2);
		arst_n <= 1'b1;
		void'($urandom(11));
		host_model_i.rd(4'hf, 8'h10);
		host_model_i.wr(4'he, 8'h40);
		host_model_i.rd(4'he, 8'h00);
		host_model_i.wr(4'hf, 8'h10);
		host_model_i.rd(4'hf, 8'h10);
		host_model_i.wr(4'hf, 8'h00);
		host_model_i.rd(4'hf, 8'h00);
		host_model_i.rd(4'h5, 8'h00);
		host_model_i.wr(4'hf, 8'h20);
		host_model_i.rd(4'hf, 8'h20);
		osc_halt <= 1'b1;
		cyc(8);
		osc_halt <= 1'b0;
		cyc(4);
		host_model_i.rd(4'hf, 8'h00);
		host_model_i.wr(4'he, 8'h10);
		host_model_i.wr(4'hf, 8'h08);
		lows(n);
		chk_pin(n > 0, 1'b0);
		host_model_i.wr(4'hf, 8'h00);
		lows(n);
		chk_pin(n > 0, 1'b1);
		// Upper comparator alone must not trip the low threshold
		host_model_i.wr(4'hf, 8'h80);
		supply_below_2v1 <= 1'b1;
		cyc(6);
		host_model_i.rd(4'hf, 8'h80);
		supply_below_1v3 <= 1'b1;
		cyc(6);
		supply_below_1v3 <= 1'b0;
		supply_below_2v1 <= 1'b0;
		cyc(6);
		host_model_i.rd(4'hf, 8'hc0);
		host_model_i.wr(4'hf, 8'hc0);
		host_model_i.rd(4'hf, 8'hc0);
		host_model_i.wr(4'hf, 8'h80);
		host_model_i.rd(4'hf, 8'h80);
		host_model_i.wr(4'he, 8'h40);
		alarm_pulse(2'b01);
		cyc(15);
		chk_pin(irq_n, 1'b1);
		cyc(10);
		chk_pin(irq_n, 1'b0);
		host_model_i.rd(4'hf, 8'h81);
		host_model_i.wr(4'hf, 8'h80);
		cyc(3);
		chk_pin(irq_n, 1'b1);
		alarm_pulse(2'b10);
		cyc(30);
		host_model_i.rd(4'hf, 8'h80);
		host_model_i.wr(4'he, 8'h04);
		for (int i = 0; i < 300 && irq_n !== 1'b0; i++) @(posedge clk);
		chk_pin(irq_n, 1'b0);
		host_model_i.rd(4'hf, 8'h84);
		host_model_i.wr(4'hf, 8'h80);
		cyc(3);
		chk_pin(irq_n, 1'b1);
		// Weekly alarm path, then month level mode, then fixed-low mode
		host_model_i.wr(4'he, 8'h80);
		alarm_pulse(2'b10);
		cyc(25);
		chk_pin(irq_n, 1'b0);
		host_model_i.rd(4'hf, 8'h82);
		host_model_i.wr(4'hf, 8'h80);
		cyc(3);
		chk_pin(irq_n, 1'b1);
		host_model_i.wr(4'he, 8'h07);
		@(posedge clk);
		month_start <= 1'b1;
		@(posedge clk);
		month_start <= 1'b0;
		cyc(3);
		chk_pin(irq_n, 1'b0);
		host_model_i.wr(4'hf, 8'h80);
		cyc(3);
		chk_pin(irq_n, 1'b1);
		host_model_i.wr(4'he, 8'h01);
		cyc(3);
		chk_pin(irq_n, 1'b0);
		host_model_i.rd(4'hf, 8'h84);
		s = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
		host_model_i.wr(4'h0, s);
		host_model_i.rd(4'h0, s);
		host_model_i.wr(4'h3, 8'hf5);
		host_model_i.rd(4'h3, 8'h05);
		// Midnight in both hour modes; seconds written last restart the divider
		for (int i = 0; i < 2; i++) begin
			host_model_i.wr(4'he, (i == 0) ? 8'h20 : 8'h00);
			host_model_i.wr(4'h3, ws[i]);
			host_model_i.wr(4'h2, hs[i]);
			host_model_i.wr(4'h1, 8'h59);
			host_model_i.wr(4'h0, 8'h59);
			cyc(150);
			host_model_i.rd(4'h0, 8'h59);
			cyc(100);
			host_model_i.rd(4'h0, 8'h00);
			host_model_i.rd(4'h1, 8'h00);
			host_model_i.rd(4'h2, he[i]);
			host_model_i.rd(4'h3, we[i]);
		end
		cyc(3);
		wrap_up();
	end
endmodule // rtc_status_flags_tb_top
`default_nettype wire
